// ---- core/pbcr_top.sv ----
/*
 * pbcr_top: processor configuration registers of the relocatable
 * 256-byte register block: block_relocation, reset_config_latch,
 * release_level and aux_configuration, plus the block hit decode.
 * Assumes the bus controller presents one internal cycle per valid pulse
 * and the chip-select unit flags upper and lower region cycles.
 */
`timescale 1ns/100ps
`default_nettype none

module pbcr_top #(
	// arbitrary neutral value, not a real part code
	parameter logic [pbcr_pkg::BYTE_W-1:0] RELEASE_CODE =
		pbcr_pkg::RELEASE_CODE_DEFAULT
) (
	// clock and reset
	input  wire logic                         ref_clk_in,
	input  wire logic                         rst_b_in,
	input  wire logic                         watchdog_reset_in,

	// internal bus cycle
	input  wire logic                         cyc_valid_in,
	input  wire logic [pbcr_pkg::ADDR_W-1:0]  cyc_addr_in,
	input  wire logic                         cyc_mem_in,
	input  wire logic                         cyc_write_in,
	input  wire logic [pbcr_pkg::BE_W-1:0]    cyc_byte_en_in,
	input  wire logic [pbcr_pkg::REG_W-1:0]   cyc_wdata_in,
	input  wire logic                         cyc_upper_region_in,
	input  wire logic                         cyc_lower_region_in,

	// internal bus answer
	output logic                              block_hit_out,
	output logic                              ignore_ext_bus_out,
	output logic                              cyc_width8_out,
	output logic                              reg_ack_out,
	output logic [pbcr_pkg::REG_W-1:0]        reg_rdata_out,

	// muxed address/data bus pins
	input  wire logic [pbcr_pkg::REG_W-1:0]   muxed_bus_lines_in,
	input  wire logic [pbcr_pkg::REG_W-1:0]   bus_drive_data_in,
	input  wire logic                         bus_drive_req_in,
	output logic [pbcr_pkg::REG_W-1:0]        muxed_bus_lines_out,
	output logic                              muxed_bus_lines_oe_out,

	// strap pin
	input  wire logic                         boot_width_strap_in,

	// configuration outputs
	output logic                              slave_mode_out,
	output logic                              port1_rx_enable_request_out,
	output logic                              port1_send_request_select_out,
	output logic                              port0_rx_enable_request_out,
	output logic                              port0_send_request_select_out,
	output logic                              upper_region_width_out,
	output logic                              lower_region_width_out,
	output logic                              middle_region_width_out,
	output logic                              io_space_width_out
);

	// ************************************************************
	// functions
	// ************************************************************

	// register block hit against the programmed base and space
	function automatic logic pbcr_block_hit(
		input logic [pbcr_pkg::ADDR_W-1:0] addr,
		input logic                        is_mem,
		input logic [pbcr_pkg::REG_W-1:0]  reloc
	);
		logic hit;
		hit = 1'b0;
		if (reloc[pbcr_pkg::RELOC_MEM_BIT] == is_mem) begin
			if (is_mem) begin
				hit = (addr[pbcr_pkg::MEM_ADDR_MSB:pbcr_pkg::PAGE_LSB] ==
					reloc[pbcr_pkg::RELOC_FIELD_MSB:0]);
			end else begin
				// base bits 19..16 play no part in I/O space
				hit = (addr[pbcr_pkg::IO_ADDR_MSB:pbcr_pkg::PAGE_LSB] ==
					reloc[pbcr_pkg::RELOC_IO_MSB:0]);
			end
		end
		return hit;
	endfunction

	// offset within the block to register select
	function automatic pbcr_pkg::pbcr_sel_t pbcr_reg_sel(
		input logic [pbcr_pkg::OFS_W-1:0] ofs
	);
		pbcr_pkg::pbcr_sel_t sel;
		sel = pbcr_pkg::SEL_NONE;
		case (ofs)
			pbcr_pkg::OFS_AUX_CONFIG: begin
				sel = pbcr_pkg::SEL_AUX;
			end
			pbcr_pkg::OFS_RELEASE: begin
				sel = pbcr_pkg::SEL_RELEASE;
			end
			pbcr_pkg::OFS_RESET_LATCH: begin
				sel = pbcr_pkg::SEL_RESET_LATCH;
			end
			pbcr_pkg::OFS_RELOCATION: begin
				sel = pbcr_pkg::SEL_RELOCATION;
			end
			default: begin
				sel = pbcr_pkg::SEL_NONE;
			end
		endcase
		return sel;
	endfunction

	// byte-lane merge of a write into a 16-bit register
	function automatic logic [pbcr_pkg::REG_W-1:0] pbcr_merge(
		input logic [pbcr_pkg::REG_W-1:0] old_val,
		input logic [pbcr_pkg::REG_W-1:0] wdata,
		input logic [pbcr_pkg::BE_W-1:0]  be
	);
		logic [pbcr_pkg::REG_W-1:0] val;
		val = old_val;
		if (be[0]) begin
			val[pbcr_pkg::BYTE_W-1:0] = wdata[pbcr_pkg::BYTE_W-1:0];
		end
		if (be[1]) begin
			val[pbcr_pkg::REG_W-1:pbcr_pkg::BYTE_W] =
				wdata[pbcr_pkg::REG_W-1:pbcr_pkg::BYTE_W];
		end
		return val;
	endfunction

	// ************************************************************
	// reset synchroniser
	// ************************************************************

	logic [1:0] rst_pipe;
	logic       rst_sync_b;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end

	assign rst_sync_b = rst_pipe[1];

	// ************************************************************
	// reset capture
	// ************************************************************

	pbcr_cap_if cap_bus ();

	assign cap_bus.in_reset = ~rst_sync_b;

	pbcr_reset_capture u_capture (
		.ref_clk_in          (ref_clk_in),
		.muxed_bus_lines_in  (muxed_bus_lines_in),
		.boot_width_strap_in (boot_width_strap_in),
		.cap                 (cap_bus.cap)
	);

	// ************************************************************
	// register state
	// ************************************************************

	pbcr_pkg::pbcr_top_state_t st;
	pbcr_pkg::pbcr_top_state_t next_st;
	logic                      hit;
	pbcr_pkg::pbcr_sel_t       sel;
	logic [pbcr_pkg::REG_W-1:0] aux_word;
	logic [pbcr_pkg::REG_W-1:0] aux_merged;

	assign hit = cyc_valid_in &&
		pbcr_block_hit(cyc_addr_in, cyc_mem_in, st.relocation);
	assign sel = pbcr_reg_sel(cyc_addr_in[pbcr_pkg::OFS_W-1:0]);
	assign aux_word = {pbcr_pkg::RESERVED_BYTE, st.aux};
	assign aux_merged = pbcr_merge(aux_word, cyc_wdata_in, cyc_byte_en_in);

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		if (st.load_pending || watchdog_reset_in) begin
			// first edge after release, or a watchdog reset
			next_st.relocation = pbcr_pkg::RELOC_RESET;
			next_st.aux = pbcr_pkg::AUX_RESET;
			next_st.aux[pbcr_pkg::AUX_UPPER_WIDTH] =
				cap_bus.strap_low;
			next_st.load_pending = 1'b0;
		end else if (hit && (sel != pbcr_pkg::SEL_NONE)) begin
			next_st.ack = 1'b1;
			if (cyc_write_in) begin
				case (sel)
					pbcr_pkg::SEL_RELOCATION: begin
						next_st.relocation = pbcr_merge(st.relocation,
							cyc_wdata_in, cyc_byte_en_in);
					end
					pbcr_pkg::SEL_AUX: begin
						// upper byte is reserved, only low lane lands
						next_st.aux = aux_merged[pbcr_pkg::AUX_W-1:0];
						if (!st.aux[pbcr_pkg::AUX_UPPER_WIDTH]) begin
							// no way back from 16-bit to 8-bit
							next_st.aux[pbcr_pkg::AUX_UPPER_WIDTH] =
								1'b0;
						end
					end
					default: begin
						// latch and release level ignore writes
						next_st.aux = st.aux;
					end
				endcase
			end else begin
				case (sel)
					pbcr_pkg::SEL_RELOCATION: begin
						next_st.rdata = st.relocation;
					end
					pbcr_pkg::SEL_AUX: begin
						next_st.rdata = aux_word;
					end
					pbcr_pkg::SEL_RELEASE: begin
						next_st.rdata = {RELEASE_CODE,
							pbcr_pkg::RESERVED_BYTE};
					end
					pbcr_pkg::SEL_RESET_LATCH: begin
						next_st.rdata =
							cap_bus.captured_bus_bits;
					end
					default: begin
						next_st.rdata = pbcr_pkg::READ_ZERO;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st.relocation <= pbcr_pkg::RELOC_RESET;
			st.aux <= pbcr_pkg::AUX_RESET;
			st.load_pending <= 1'b1;
			st.ack <= 1'b0;
			st.rdata <= pbcr_pkg::READ_ZERO;
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// bus answer
	// ************************************************************

	assign block_hit_out = hit;
	// internal cycles run externally but take no data or ready from pins
	assign ignore_ext_bus_out = hit;
	assign reg_ack_out = st.ack;
	assign reg_rdata_out = st.rdata;

	// width of the current external cycle
	always_comb begin
		if (hit) begin
			cyc_width8_out = 1'b0;
		end else if (!cyc_mem_in) begin
			cyc_width8_out = st.aux[pbcr_pkg::AUX_IO_WIDTH];
		end else if (cyc_upper_region_in) begin
			cyc_width8_out = st.aux[pbcr_pkg::AUX_UPPER_WIDTH];
		end else if (cyc_lower_region_in) begin
			cyc_width8_out = st.aux[pbcr_pkg::AUX_LOWER_WIDTH];
		end else begin
			cyc_width8_out = st.aux[pbcr_pkg::AUX_MIDDLE_WIDTH];
		end
	end

	// ************************************************************
	// muxed bus pins
	// ************************************************************

	// never drive the lines while the configuration is being sampled
	assign muxed_bus_lines_oe_out = bus_drive_req_in && rst_sync_b;
	assign muxed_bus_lines_out = bus_drive_data_in;

	// ************************************************************
	// configuration outputs
	// ************************************************************

	assign slave_mode_out =
		st.relocation[pbcr_pkg::RELOC_SLAVE_BIT];
	assign port1_rx_enable_request_out =
		st.aux[pbcr_pkg::AUX_P1_RX_ENABLE];
	assign port1_send_request_select_out =
		st.aux[pbcr_pkg::AUX_P1_SEND_REQ];
	assign port0_rx_enable_request_out =
		st.aux[pbcr_pkg::AUX_P0_RX_ENABLE];
	assign port0_send_request_select_out =
		st.aux[pbcr_pkg::AUX_P0_SEND_REQ];
	assign upper_region_width_out = st.aux[pbcr_pkg::AUX_UPPER_WIDTH];
	assign lower_region_width_out = st.aux[pbcr_pkg::AUX_LOWER_WIDTH];
	assign middle_region_width_out = st.aux[pbcr_pkg::AUX_MIDDLE_WIDTH];
	assign io_space_width_out = st.aux[pbcr_pkg::AUX_IO_WIDTH];

endmodule

`default_nettype wire

// ---- core/pbcr_pkg.sv ----
/*
 * pbcr_pkg: offsets, field positions, reset values, widths and state
 * types of the processor configuration registers of the register block.
 * Assumes every user names items as pbcr_pkg::name, with no import.
 */
package pbcr_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int REG_W  = 16;
	localparam int ADDR_W = 20;
	localparam int OFS_W  = 8;
	localparam int AUX_W  = 8;
	localparam int BYTE_W = 8;
	localparam int BE_W   = 2;

	// ************************************************************
	// register offsets inside the 256-byte register block
	// ************************************************************
	localparam logic [OFS_W-1:0] OFS_AUX_CONFIG   = 8'hf2;
	localparam logic [OFS_W-1:0] OFS_RELEASE      = 8'hf4;
	localparam logic [OFS_W-1:0] OFS_RESET_LATCH  = 8'hf6;
	localparam logic [OFS_W-1:0] OFS_RELOCATION   = 8'hfe;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [REG_W-1:0] RELOC_RESET = 16'h20ff;
	localparam logic [AUX_W-1:0] AUX_RESET   = 8'h00;
	localparam logic [BYTE_W-1:0] RESERVED_BYTE = 8'h00;
	localparam logic [REG_W-1:0] READ_ZERO   = 16'h0000;
	// arbitrary neutral value, not a real part code
	localparam logic [BYTE_W-1:0] RELEASE_CODE_DEFAULT = 8'h5a;

	// ************************************************************
	// block_relocation fields
	// ************************************************************
	localparam int RELOC_SLAVE_BIT = 14;
	localparam int RELOC_MEM_BIT   = 12;
	localparam int RELOC_FIELD_MSB = 11;
	localparam int RELOC_IO_MSB    = 7;
	localparam int PAGE_LSB        = 8;
	localparam int MEM_ADDR_MSB    = 19;
	localparam int IO_ADDR_MSB     = 15;

	// ************************************************************
	// aux_configuration fields
	// ************************************************************
	localparam int AUX_UPPER_WIDTH  = 7;
	localparam int AUX_P1_RX_ENABLE = 6;
	localparam int AUX_P1_SEND_REQ  = 5;
	localparam int AUX_P0_RX_ENABLE = 4;
	localparam int AUX_P0_SEND_REQ  = 3;
	localparam int AUX_LOWER_WIDTH  = 2;
	localparam int AUX_MIDDLE_WIDTH = 1;
	localparam int AUX_IO_WIDTH     = 0;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_AUX,
		SEL_RELEASE,
		SEL_RESET_LATCH,
		SEL_RELOCATION
	} pbcr_sel_t;

	typedef struct packed {
		logic [REG_W-1:0] ad_meta;
		logic [REG_W-1:0] ad_sync;
		logic             strap_meta;
		logic             strap_sync;
		logic [REG_W-1:0] captured_bus_bits;
		logic             strap_low;
	} pbcr_cap_state_t;

	typedef struct packed {
		logic [REG_W-1:0] relocation;
		logic [AUX_W-1:0] aux;
		logic             load_pending;
		logic             ack;
		logic [REG_W-1:0] rdata;
	} pbcr_top_state_t;

endpackage

// ---- core/pbcr_cap_if.sv ----
/*
 * pbcr_cap_if: carries the reset-time capture results from the capture
 * module to the register top. Assumes one clock domain for both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface pbcr_cap_if;
	logic                        in_reset;
	logic [pbcr_pkg::REG_W-1:0]  captured_bus_bits;
	logic                        strap_low;

	modport top (
		output in_reset,
		input  captured_bus_bits,
		input  strap_low
	);
	modport cap (
		input  in_reset,
		output captured_bus_bits,
		output strap_low
	);
endinterface

`default_nettype wire

// ---- core/pbcr_reset_capture.sv ----
/*
 * pbcr_reset_capture: synchronises the muxed bus lines and the boot width
 * strap, and captures both while the external reset is held.
 * Assumes the clock runs during reset; in_reset comes from the top's
 * synchronised reset copy. No async reset here on purpose: the captured
 * values must survive into the time after reset.
 */
`timescale 1ns/100ps
`default_nettype none

module pbcr_reset_capture (
	// clock
	input  wire logic                        ref_clk_in,
	// pins
	input  wire logic [pbcr_pkg::REG_W-1:0]  muxed_bus_lines_in,
	input  wire logic                        boot_width_strap_in,
	// capture results
	pbcr_cap_if.cap                          cap
);

	pbcr_pkg::pbcr_cap_state_t st;
	pbcr_pkg::pbcr_cap_state_t next_st;

	always_comb begin
		next_st = st;
		next_st.ad_meta = muxed_bus_lines_in;
		next_st.ad_sync = st.ad_meta;
		next_st.strap_meta = boot_width_strap_in;
		next_st.strap_sync = st.strap_meta;
		if (cap.in_reset) begin
			next_st.captured_bus_bits = st.ad_sync;
			next_st.strap_low = ~st.strap_sync;
		end
	end

	// held unchanged once reset is released
	always_ff @(posedge ref_clk_in) begin
		st <= next_st;
	end

	assign cap.captured_bus_bits = st.captured_bus_bits;
	assign cap.strap_low = st.strap_low;

endmodule

`default_nettype wire

// ---- verification/pbcr_top_asserts.sv ----
/* pbcr_top_asserts: port-level timing checks of the configuration registers.
   assumes the bind below and one clock domain on ref_clk_in. */
`timescale 1ns/100ps
`default_nettype none
module pbcr_top_asserts #(
	parameter logic [pbcr_pkg::BYTE_W-1:0] RELEASE_CODE =
		pbcr_pkg::RELEASE_CODE_DEFAULT
) (
	// clock and reset
	input wire logic	ref_clk_in,
	input wire logic	rst_b_in,
	input wire logic	watchdog_reset_in,
	// bus cycle and pins
	input wire logic	cyc_valid_in,
	input wire logic [19:0]	cyc_addr_in,
	input wire logic	cyc_write_in,
	input wire logic [1:0]	cyc_byte_en_in,
	input wire logic [15:0]	bus_drive_data_in,
	input wire logic	bus_drive_req_in,
	// answers
	input wire logic	block_hit_out,
	input wire logic	ignore_ext_bus_out,
	input wire logic	cyc_width8_out,
	input wire logic	reg_ack_out,
	input wire logic [15:0]	reg_rdata_out,
	input wire logic [15:0]	muxed_bus_lines_out,
	input wire logic	muxed_bus_lines_oe_out,
	// configuration
	input wire logic	slave_mode_out,
	input wire logic	port1_rx_enable_request_out,
	input wire logic	port1_send_request_select_out,
	input wire logic	port0_rx_enable_request_out,
	input wire logic	port0_send_request_select_out,
	input wire logic	upper_region_width_out,
	input wire logic	lower_region_width_out,
	input wire logic	middle_region_width_out,
	input wire logic	io_space_width_out
);
	// ************************************************************
	// helpers
	// ************************************************************
	logic [7:0]	ofs;
	logic		take;
	logic [6:0]	aux_lo;
	assign ofs = cyc_addr_in[7:0];
	assign take = cyc_valid_in && block_hit_out && (ofs == 8'hf2 ||
		ofs == 8'hf4 || ofs == 8'hf6 || ofs == 8'hfe);
	assign aux_lo = {port1_rx_enable_request_out,
		port1_send_request_select_out, port0_rx_enable_request_out,
		port0_send_request_select_out, lower_region_width_out,
		middle_region_width_out, io_space_width_out};
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// ************************************************************
	// properties
	// ************************************************************
	property p_ack_cause;
		reg_ack_out |-> $past(take);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	// the load step and the first edges after release drop requests
	property p_ack_time;
		rst_b_in[*3] ##1 (take && !watchdog_reset_in) |=> reg_ack_out;
	endproperty
	a_ack_time: assert property (p_ack_time) else $error("ack late");
	property p_hit_lines;
		ignore_ext_bus_out == block_hit_out &&
			(!block_hit_out || (cyc_valid_in && !cyc_width8_out));
	endproperty
	a_hit_lines: assert property (p_hit_lines) else $error("hit flags");
	property p_oe;
		muxed_bus_lines_oe_out |-> bus_drive_req_in && $past(rst_b_in, 2)
			&& muxed_bus_lines_out == bus_drive_data_in;
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven early");
	property p_slave;
		$changed(slave_mode_out) |-> $past(watchdog_reset_in) ||
			$past(take && cyc_write_in && cyc_byte_en_in[1] && ofs == 8'hfe);
	endproperty
	a_slave: assert property (p_slave) else $error("slave mode moved");
	property p_aux_low;
		$changed(aux_lo) |-> $past(watchdog_reset_in) ||
			$past(take && cyc_write_in && cyc_byte_en_in[0] && ofs == 8'hf2);
	endproperty
	a_aux_low: assert property (p_aux_low) else $error("aux bits moved");
	property p_upper;
		$rose(upper_region_width_out) |->
			$past(watchdog_reset_in) || !$past(rst_b_in, 4);
	endproperty
	a_upper: assert property (p_upper) else $error("upper width set");
	property p_rel_read;
		(take && !cyc_write_in && ofs == 8'hf4) ##1 reg_ack_out |->
			reg_rdata_out == {RELEASE_CODE, 8'h00};
	endproperty
	a_rel_read: assert property (p_rel_read) else $error("release code");
	property p_aux_read;
		(take && !cyc_write_in && ofs == 8'hf2) ##1 reg_ack_out |->
			reg_rdata_out[15:7] == {8'h00, upper_region_width_out};
	endproperty
	a_aux_read: assert property (p_aux_read) else $error("aux read");
	c_write: cover property (take && cyc_write_in);
	c_watchdog: cover property (watchdog_reset_in);
	c_slave: cover property ($rose(slave_mode_out));
endmodule
bind pbcr_top pbcr_top_asserts #(.RELEASE_CODE(RELEASE_CODE))
	u_pbcr_top_asserts (.*);
`default_nettype wire

// ---- verification/pbcr_bus_model.sv ----
/* pbcr_bus_model: bus controller and board side of pbcr_top.
   assumes the testbench calls access and sets pulls and strap_low. */
`timescale 1ns/100ps
`default_nettype none
module pbcr_bus_model (
	// clock
	input wire logic	ref_clk_in,
	// internal bus cycle
	output logic		cyc_valid_out,
	output logic [19:0]	cyc_addr_out,
	output logic		cyc_mem_out,
	output logic		cyc_write_out,
	output logic [1:0]	cyc_byte_en_out,
	output logic [15:0]	cyc_wdata_out,
	output logic		cyc_upper_out,
	output logic		cyc_lower_out,
	// answers
	input wire logic	block_hit_in,
	input wire logic	cyc_width8_in,
	input wire logic	reg_ack_in,
	input wire logic [15:0]	reg_rdata_in,
	// board pins
	input wire logic [15:0]	bus_drive_in,
	input wire logic	bus_oe_in,
	output logic [15:0]	bus_lines_out,
	output logic		strap_out
);
	// ************************************************************
	// board levels and cycles
	// ************************************************************
	logic [15:0]	pulls;
	logic		strap_low;
	// weak pulls set the level whenever the device lets go of the lines
	assign bus_lines_out = bus_oe_in ? bus_drive_in : pulls;
	assign strap_out = !strap_low;
	initial begin
		{cyc_valid_out, cyc_addr_out, cyc_mem_out, cyc_write_out} = '0;
		{cyc_byte_en_out, cyc_wdata_out, cyc_upper_out, cyc_lower_out} = '0;
	end
	task automatic access(input logic [19:0] a, input logic m, w,
		input logic [1:0] be, rg, input logic [15:0] d,
		output logic h, w8, k, output logic [15:0] rd);
		@(negedge ref_clk_in);
		{cyc_addr_out, cyc_mem_out, cyc_write_out} = {a, m, w};
		{cyc_byte_en_out, cyc_upper_out, cyc_lower_out} = {be, rg};
		cyc_wdata_out = d;
		cyc_valid_out = 1'h1;
		#1;
		h = block_hit_in;
		w8 = cyc_width8_in;
		@(negedge ref_clk_in);
		k = reg_ack_in;
		rd = reg_rdata_in;
		cyc_valid_out = 1'h0;
		// stale write data would hide a missing valid qualifier
		cyc_wdata_out = ~d;
	endtask
endmodule
`default_nettype wire

// ---- verification/pbcr_top_tb_top.sv ----
/* pbcr_top_tb_top: register-level tests of pbcr_top through a bus model.
   assumes the checker binds itself and a 100 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module pbcr_top_tb_top;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic ref_clk_in, rst_b_in, watchdog_reset_in, bus_drive_req_in;
	logic cyc_valid_in, cyc_mem_in, cyc_write_in, boot_width_strap_in;
	logic cyc_upper_region_in, cyc_lower_region_in, block_hit_out;
	logic ignore_ext_bus_out, cyc_width8_out, reg_ack_out, slave_mode_out;
	logic muxed_bus_lines_oe_out, h, w8, k;
	logic port1_rx_enable_request_out, port1_send_request_select_out;
	logic port0_rx_enable_request_out, port0_send_request_select_out;
	logic upper_region_width_out, lower_region_width_out;
	logic middle_region_width_out, io_space_width_out;
	logic [1:0]	cyc_byte_en_in;
	logic [19:0]	cyc_addr_in;
	logic [15:0]	cyc_wdata_in, reg_rdata_out, muxed_bus_lines_in;
	logic [15:0]	bus_drive_data_in, muxed_bus_lines_out, rd;
	int		err_total, checked;
	pbcr_top u_pbcr_top (.*);
	pbcr_bus_model u_pbcr_bus_model (.ref_clk_in,
		.cyc_valid_out(cyc_valid_in), .cyc_addr_out(cyc_addr_in),
		.cyc_mem_out(cyc_mem_in), .cyc_write_out(cyc_write_in),
		.cyc_byte_en_out(cyc_byte_en_in), .cyc_wdata_out(cyc_wdata_in),
		.cyc_upper_out(cyc_upper_region_in),
		.cyc_lower_out(cyc_lower_region_in), .block_hit_in(block_hit_out),
		.cyc_width8_in(cyc_width8_out), .reg_ack_in(reg_ack_out),
		.reg_rdata_in(reg_rdata_out), .bus_drive_in(muxed_bus_lines_out),
		.bus_oe_in(muxed_bus_lines_oe_out), .bus_lines_out(muxed_bus_lines_in),
		.strap_out(boot_width_strap_in));
	always #5 ref_clk_in = ~ref_clk_in;
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic probe(input logic [19:0] a, input logic m,
		input logic [1:0] rg);
		u_pbcr_bus_model.access(a, m, 1'h0, 2'h3, rg, 16'h0000, h, w8, k, rd);
	endtask
	task automatic rd_chk(input logic [19:0] a, input logic m,
		input logic [15:0] e);
		probe(a, m, 2'h0);
		chk(16'({h, k}), 16'h0003);
		chk(rd, e);
	endtask
	task automatic wr(input logic [19:0] a, input logic m, input logic [1:0] be,
		input logic [15:0] d);
		u_pbcr_bus_model.access(a, m, 1'h1, be, 2'h0, d, h, w8, k, rd);
		chk(16'({h, k}), 16'h0003);
	endtask
	// e lists the expected width for upper, lower, middle and i/o cycles
	task automatic widths(input logic [3:0] e);
		logic [19:0] ad [4];
		ad = '{20'hf0000, 20'h00100, 20'h40000, 20'h00300};
		for (int i = 0; i < 4; i++) begin
			probe(ad[i], i < 3, {i == 0, i == 1});
			chk(16'(w8), 16'(e[3-i]));
		end
	endtask
	task automatic do_reset(input logic [15:0] p, input logic sl);
		u_pbcr_bus_model.pulls = p;
		u_pbcr_bus_model.strap_low = sl;
		rst_b_in = 1'h0;
		repeat (10) @(negedge ref_clk_in);
		chk(16'(muxed_bus_lines_oe_out), 16'h0000);
		rst_b_in = 1'h1;
		repeat (3) @(negedge ref_clk_in);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		ref_clk_in = 1'h0;
		watchdog_reset_in = 1'h0;
		bus_drive_req_in = 1'h1;
		bus_drive_data_in = 16'h3c3c;
		err_total = 0;
		checked = 0;
		do_reset(16'ha5c3, 1'h1);
		rd_chk(20'h0fffe, 1'h0, 16'h20ff);
		chk(16'(slave_mode_out), 16'h0000);
		rd_chk(20'h0fff2, 1'h0, 16'h0080);
		rd_chk(20'h0fff6, 1'h0, 16'ha5c3);
		rd_chk(20'h0fff4, 1'h0, 16'h5a00);
		chk(muxed_bus_lines_in, 16'h3c3c);
		u_pbcr_bus_model.pulls = 16'h1234;
		wr(20'h0fff6, 1'h0, 2'h3, 16'hffff);
		wr(20'h0fff4, 1'h0, 2'h3, 16'hffff);
		rd_chk(20'h0fff6, 1'h0, 16'ha5c3);
		rd_chk(20'h0fff4, 1'h0, 16'h5a00);
		probe(20'h0fff0, 1'h0, 2'h0);
		chk(16'({h, k}), 16'h0002);
		probe(20'h0fffe, 1'h1, 2'h0);
		chk(16'({h, k}), 16'h0000);
		wr(20'h0fff2, 1'h0, 2'h3, 16'hffff);
		rd_chk(20'h0fff2, 1'h0, 16'h00ff);
		chk(16'({port1_rx_enable_request_out, port1_send_request_select_out,
			port0_rx_enable_request_out, port0_send_request_select_out}),
			16'h000f);
		wr(20'h0fff2, 1'h0, 2'h1, 16'h1283);
		widths(4'hb);
		wr(20'h0fff2, 1'h0, 2'h1, 16'h0004);
		widths(4'h4);
		wr(20'h0fff2, 1'h0, 2'h3, 16'h0084);
		rd_chk(20'h0fff2, 1'h0, 16'h0004);
		wr(20'h0fffe, 1'h0, 2'h3, 16'h9012);
		rd_chk(20'h012fe, 1'h1, 16'h9012);
		probe(20'h0fffe, 1'h0, 2'h0);
		chk(16'(h), 16'h0000);
		wr(20'h012fe, 1'h1, 2'h1, 16'hff34);
		rd_chk(20'h034fe, 1'h1, 16'h9034);
		wr(20'h034fe, 1'h1, 2'h3, 16'hc055);
		chk(16'(slave_mode_out), 16'h0001);
		rd_chk(20'hf55fe, 1'h0, 16'hc055);
		u_pbcr_bus_model.strap_low = 1'h0;
		watchdog_reset_in = 1'h1;
		@(negedge ref_clk_in);
		watchdog_reset_in = 1'h0;
		chk(16'(slave_mode_out), 16'h0000);
		rd_chk(20'h0fffe, 1'h0, 16'h20ff);
		rd_chk(20'h0fff2, 1'h0, 16'h0080);
		rd_chk(20'h0fff6, 1'h0, 16'ha5c3);
		do_reset(16'h5a5a, 1'h0);
		rd_chk(20'h0fff2, 1'h0, 16'h0000);
		rd_chk(20'h0fff6, 1'h0, 16'h5a5a);
		conclude();
	end
endmodule
`default_nettype wire
